// >>> hdl/sbm_regs.vh
// Constants for the system-control and block-move execution unit.
// Assumes inclusion by bare name from files in the same folder.
`ifndef SBM_REGS_VH
`define SBM_REGS_VH

// Main operation field, always the top four bits of the first word.
`define SBM_OP_SYS       4'h0
`define SBM_OP_BCC       4'h4
`define SBM_OP_IMM       4'h6
`define SBM_OP_BIT       4'h7

// Second operation field of the system group.
`define SBM_SYS_NOP      4'h0
`define SBM_SYS_TRAP     4'h1
`define SBM_SYS_RTE      4'h2
`define SBM_SYS_SLEEP    4'h3
`define SBM_SYS_LDC_IMM  4'h4
`define SBM_SYS_LDC_REG  4'h5
`define SBM_SYS_LDC_MEM  4'h6
`define SBM_SYS_STC_REG  4'h7
`define SBM_SYS_STC_MEM  4'h8
`define SBM_SYS_AND_FLAGS_IMM_INSTR     4'h9
`define SBM_SYS_ORC      4'ha
`define SBM_SYS_XOR_FLAGS_IMM_INSTR     4'hb
`define SBM_SYS_MOVB     4'hc
`define SBM_SYS_MOVW     4'hd

// Second operation field of the extension-word group.
`define SBM_IMM_W16      4'h0
`define SBM_IMM_L32      4'h1
`define SBM_IMM_A24      4'h2

// Second operation field of the bit group.
`define SBM_BIT_SET      4'h0
`define SBM_BIT_CLR      4'h1
`define SBM_BIT_NOT      4'h2
`define SBM_BIT_ST       4'h3
`define SBM_BIT_IST      4'h4

// Flag positions inside the condition code register.
`define SBM_CCR_C        0
`define SBM_CCR_V        1
`define SBM_CCR_Z        2
`define SBM_CCR_N        3
`define SBM_CCR_I        7
`define SBM_CCR_RST      8'h80

// Access sizes and post-increment amounts.
`define SBM_SZ_BYTE      2'd0
`define SBM_SZ_WORD      2'd1
`define SBM_SZ_LONG      2'd2
`define SBM_INC_BYTE     32'h00000001
`define SBM_INC_WORD     32'h00000002
`define SBM_INC_LONG     32'h00000004

// Program counter.
`define SBM_PC_RST       24'h000100
`define SBM_PC_STEP      24'h000002

// Byte-wide on-chip registers answered inside the block.
`define SBM_PDIR_ADDR    24'hfffe00
`define SBM_ISR_ADDR     24'hfffe01
`define SBM_PDIR_RST     8'h00
`define SBM_WO_READ      8'hff

`endif

// >>> hdl/sbm_onchip_regs.v
// Byte-wide on-chip registers: a write-only direction register and an
// interrupt status register whose flags clear only after a read as set.
// Assumes one access strobe per completed bus step on the core clock.
`default_nettype none
`include "sbm_regs.vh"

module sbm_onchip_regs (
  input  wire        clk,
  input  wire        nrst,
  input  wire        acc,
  input  wire        we,
  input  wire [23:0] addr,
  input  wire [7:0]  wdata,
  input  wire [7:0]  irq_evt,
  output wire        hit,
  output wire [7:0]  rdata,
  output wire [7:0]  port_dir,
  output wire [7:0]  irq_status
);

  reg  [7:0] pdir_r;
  reg  [7:0] isr_r;
  reg  [7:0] armed_r;
  wire       pdir_sel;
  wire       isr_sel;
  wire [7:0] clr_ok;

  assign pdir_sel   = (addr == `SBM_PDIR_ADDR);
  assign isr_sel    = (addr == `SBM_ISR_ADDR);
  assign hit        = pdir_sel | isr_sel;
  // A read-modify-write of the direction register stores ones into every bit it did not touch.
  assign rdata      = pdir_sel ? `SBM_WO_READ : isr_r;
  assign port_dir   = pdir_r;
  assign irq_status = isr_r;
  assign clr_ok     = armed_r & ~wdata;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pdir_r  <= `SBM_PDIR_RST;
      isr_r   <= 8'h00;
      armed_r <= 8'h00;
    end else begin
      if (acc && we && pdir_sel) begin
        pdir_r <= wdata;
      end
      // A new event in the clearing cycle wins over the clear.
      if (acc && we && isr_sel) begin
        isr_r   <= (isr_r & ~clr_ok) | irq_evt;
        armed_r <= 8'h00;
      end else begin
        isr_r <= isr_r | irq_evt;
        if (acc && !we && isr_sel) begin
          armed_r <= armed_r | isr_r;
        end
      end
    end
  end

endmodule // sbm_onchip_regs

`default_nettype wire

// >>> hdl/sbm_exec.v
// Execution unit for system control, flag logic, block move and
// read-modify-write bit instructions of a 16-bit core.
// Assumes a fetch source that presents the word at fetch_addr in order,
// and a memory bus that answers each request with a one-cycle mem_ack.
`default_nettype none
`include "sbm_regs.vh"

module sbm_exec (
  input  wire        clk,
  input  wire        nrst,
  input  wire        fetch_valid,
  input  wire [15:0] fetch_word,
  output wire        fetch_ready,
  output wire [23:0] fetch_addr,
  output wire        mem_req,
  output wire        mem_we,
  output wire        mem_word,
  output wire [23:0] mem_addr,
  output wire [15:0] mem_wdata,
  input  wire [15:0] mem_rdata,
  input  wire        mem_ack,
  input  wire        exc_entry_valid,
  input  wire [23:0] exc_entry_pc,
  input  wire        wake,
  input  wire [7:0]  irq_evt,
  output wire        trap_start,
  output wire [1:0]  trap_vec,
  output wire        exc_return,
  output wire        power_down,
  output wire        illegal_instr,
  output wire [7:0]  condition_code_reg,
  output wire [7:0]  port_dir,
  output wire [7:0]  irq_status
);

  localparam [6:0] S_FETCH = 7'b0000001;
  localparam [6:0] S_EXT1  = 7'b0000010;
  localparam [6:0] S_EXT2  = 7'b0000100;
  localparam [6:0] S_RD    = 7'b0001000;
  localparam [6:0] S_WR    = 7'b0010000;
  localparam [6:0] S_WAIT  = 7'b0100000;
  localparam [6:0] S_SLEEP = 7'b1000000;

  localparam [1:0] K_LDC = 2'd0;
  localparam [1:0] K_STC = 2'd1;
  localparam [1:0] K_MOV = 2'd2;
  localparam [1:0] K_RMW = 2'd3;

  reg  [6:0]  state_r;
  reg  [23:0] pc_r;
  reg  [7:0]  ccr_r;
  reg  [15:0] ir_r;
  reg  [15:0] ext_hi_r;
  reg  [1:0]  kind_r;
  reg         wcount_r;
  reg  [2:0]  bitn_r;
  reg  [23:0] addr_r;
  reg         we_r;
  reg         word_r;
  reg  [15:0] wdata_r;
  reg  [23:0] save_pc_r;
  reg  [7:0]  save_ccr_r;
  reg         trap_start_r;
  reg  [1:0]  trap_vec_r;
  reg         exc_ret_r;
  reg         illegal_r;
  reg  [31:0] er_r [0:7];
  integer     i;

  wire [3:0]  op_main;
  wire [3:0]  op_sub;
  wire [31:0] ea_reg;
  wire [31:0] sel_reg;
  wire [7:0]  src_byte;
  wire [31:0] ptr_reg;
  wire [15:0] cnt_left;
  wire [31:0] ext_val;
  wire        bus_step;
  wire        on_hit;
  wire [7:0]  on_rdata;
  wire        bus_done;
  wire [15:0] rd_data;
  wire [23:0] br_target;

  // Field split of the first word; the top nibble is always operation.
  assign op_main   = fetch_word[15:12];
  assign op_sub    = fetch_word[11:8];
  // Three-bit address register field and four-bit byte register field.
  assign ea_reg    = er_r[fetch_word[2:0]];
  assign sel_reg   = er_r[fetch_word[2:0]];
  assign src_byte  = fetch_word[3] ? sel_reg[7:0] : sel_reg[15:8];
  assign ptr_reg   = er_r[ir_r[6:4]];
  assign cnt_left  = wcount_r ? (er_r[4][15:0] - 16'h0001)
                              : {8'h00, er_r[4][7:0] - 8'h01};
  assign ext_val   = {ext_hi_r, fetch_word};
  assign br_target = pc_r + `SBM_PC_STEP
                   + {{16{fetch_word[7]}}, fetch_word[7:0]};
  assign bus_step  = (state_r == S_RD) || (state_r == S_WR);
  assign bus_done  = on_hit || mem_ack;
  assign rd_data   = on_hit ? {on_rdata, on_rdata} : mem_rdata;

  assign fetch_ready   = (state_r == S_FETCH) || (state_r == S_EXT1)
                      || (state_r == S_EXT2);
  assign fetch_addr    = pc_r;
  assign mem_req       = bus_step && !on_hit;
  assign mem_we        = we_r;
  assign mem_word      = word_r;
  assign mem_addr      = addr_r;
  assign mem_wdata     = wdata_r;
  assign trap_start    = trap_start_r;
  assign trap_vec      = trap_vec_r;
  assign exc_return    = exc_ret_r;
  assign power_down    = (state_r == S_SLEEP);
  assign illegal_instr = illegal_r;
  assign condition_code_reg           = ccr_r;

  // Branch condition decode on the flag byte.
  function cond_true;
    input [3:0] cc;
    input [7:0] f;
    reg c, v, z, n;
    begin
      c = f[`SBM_CCR_C];
      v = f[`SBM_CCR_V];
      z = f[`SBM_CCR_Z];
      n = f[`SBM_CCR_N];
      case (cc)
        4'h0: cond_true = 1'b1;
        4'h1: cond_true = 1'b0;
        4'h2: cond_true = ~(c | z);
        4'h3: cond_true = c | z;
        4'h4: cond_true = ~c;
        4'h5: cond_true = c;
        4'h6: cond_true = ~z;
        4'h7: cond_true = z;
        4'h8: cond_true = ~v;
        4'h9: cond_true = v;
        4'ha: cond_true = ~n;
        4'hb: cond_true = n;
        4'hc: cond_true = ~(n ^ v);
        4'hd: cond_true = n ^ v;
        4'he: cond_true = ~(z | (n ^ v));
        default: cond_true = z | (n ^ v);
      endcase
    end
  endfunction

  function [31:0] inc_amt;
    input [1:0] sz;
    begin
      case (sz)
        `SBM_SZ_BYTE: inc_amt = `SBM_INC_BYTE;
        `SBM_SZ_WORD: inc_amt = `SBM_INC_WORD;
        default:      inc_amt = `SBM_INC_LONG;
      endcase
    end
  endfunction

  function [7:0] bit_modify;
    input [7:0] d;
    input [3:0] op;
    input [2:0] n;
    input       c;
    reg   [7:0] m;
    begin
      m = 8'h01 << n;
      case (op)
        `SBM_BIT_SET: bit_modify = d | m;
        `SBM_BIT_CLR: bit_modify = d & ~m;
        `SBM_BIT_NOT: bit_modify = d ^ m;
        `SBM_BIT_ST:  bit_modify = c ? (d | m) : (d & ~m);
        default:      bit_modify = c ? (d & ~m) : (d | m);
      endcase
    end
  endfunction

  sbm_onchip_regs u_onchip (
    .clk        (clk),
    .nrst       (nrst),
    .acc        (bus_step && on_hit),
    .we         (we_r),
    .addr       (addr_r),
    .wdata      (wdata_r[7:0]),
    .irq_evt    (irq_evt),
    .hit        (on_hit),
    .rdata      (on_rdata),
    .port_dir   (port_dir),
    .irq_status (irq_status)
  );

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r      <= S_FETCH;
      pc_r         <= `SBM_PC_RST;
      ccr_r        <= `SBM_CCR_RST;
      ir_r         <= 16'h0000;
      ext_hi_r     <= 16'h0000;
      kind_r       <= K_LDC;
      wcount_r     <= 1'b0;
      bitn_r       <= 3'd0;
      addr_r       <= 24'h000000;
      we_r         <= 1'b0;
      word_r       <= 1'b0;
      wdata_r      <= 16'h0000;
      save_pc_r    <= 24'h000000;
      save_ccr_r   <= 8'h00;
      trap_start_r <= 1'b0;
      trap_vec_r   <= 2'd0;
      exc_ret_r    <= 1'b0;
      illegal_r    <= 1'b0;
      for (i = 0; i < 8; i = i + 1) begin
        er_r[i] <= 32'h00000000;
      end
    end else begin
      trap_start_r <= 1'b0;
      exc_ret_r    <= 1'b0;
      illegal_r    <= 1'b0;
      case (state_r)
        S_FETCH: if (fetch_valid) begin
          ir_r <= fetch_word;
          pc_r <= pc_r + `SBM_PC_STEP;
          case (op_main)
            `SBM_OP_SYS: case (op_sub)
              `SBM_SYS_NOP: begin
              end
              `SBM_SYS_TRAP: begin
                save_pc_r    <= pc_r + `SBM_PC_STEP;
                save_ccr_r   <= ccr_r;
                ccr_r        <= ccr_r | (8'h01 << `SBM_CCR_I);
                trap_vec_r   <= fetch_word[1:0];
                trap_start_r <= 1'b1;
                state_r      <= S_WAIT;
              end
              `SBM_SYS_RTE: begin
                pc_r      <= save_pc_r;
                ccr_r     <= save_ccr_r;
                exc_ret_r <= 1'b1;
              end
              `SBM_SYS_SLEEP: state_r <= S_SLEEP;
              `SBM_SYS_LDC_IMM: ccr_r <= fetch_word[7:0];
              `SBM_SYS_LDC_REG: ccr_r <= src_byte;
              `SBM_SYS_LDC_MEM: begin
                addr_r  <= {er_r[fetch_word[6:4]][23:1], 1'b0};
                word_r  <= 1'b1;
                we_r    <= 1'b0;
                kind_r  <= K_LDC;
                state_r <= S_RD;
              end
              `SBM_SYS_STC_REG: begin
                if (fetch_word[3]) begin
                  er_r[fetch_word[2:0]][7:0] <= ccr_r;
                end else begin
                  er_r[fetch_word[2:0]][15:8] <= ccr_r;
                end
              end
              `SBM_SYS_STC_MEM: begin
                addr_r  <= {er_r[fetch_word[6:4]][23:1], 1'b0};
                wdata_r <= {ccr_r, 8'h00};
                word_r  <= 1'b1;
                we_r    <= 1'b1;
                kind_r  <= K_STC;
                state_r <= S_WR;
              end
              `SBM_SYS_AND_FLAGS_IMM_INSTR: ccr_r <= ccr_r & fetch_word[7:0];
              `SBM_SYS_ORC:  ccr_r <= ccr_r | fetch_word[7:0];
              `SBM_SYS_XOR_FLAGS_IMM_INSTR: ccr_r <= ccr_r ^ fetch_word[7:0];
              `SBM_SYS_MOVB, `SBM_SYS_MOVW: begin
                wcount_r <= op_sub[0];
                // A zero count moves nothing and falls through.
                if ((op_sub[0] && er_r[4][15:0] != 16'h0000) ||
                    (!op_sub[0] && er_r[4][7:0] != 8'h00)) begin
                  addr_r  <= er_r[5][23:0];
                  word_r  <= 1'b0;
                  we_r    <= 1'b0;
                  kind_r  <= K_MOV;
                  state_r <= S_RD;
                end
              end
              default: illegal_r <= 1'b1;
            endcase
            `SBM_OP_BCC: begin
              if (cond_true(fetch_word[11:8], ccr_r)) begin
                pc_r <= br_target;
              end
            end
            `SBM_OP_IMM: state_r <= S_EXT1;
            `SBM_OP_BIT: begin
              if (op_sub > `SBM_BIT_IST) begin
                illegal_r <= 1'b1;
              end else begin
                addr_r  <= ea_reg[23:0];
                word_r  <= 1'b0;
                we_r    <= 1'b0;
                bitn_r  <= fetch_word[7] ? er_r[fetch_word[6:4]][2:0]
                                         : fetch_word[6:4];
                kind_r  <= K_RMW;
                state_r <= S_RD;
              end
            end
            default: illegal_r <= 1'b1;
          endcase
        end
        S_EXT1: if (fetch_valid) begin
          pc_r <= pc_r + `SBM_PC_STEP;
          if (ir_r[11:8] == `SBM_IMM_W16) begin
            er_r[ir_r[2:0]][15:0] <= fetch_word;
            state_r <= S_FETCH;
          end else begin
            ext_hi_r <= fetch_word;
            state_r  <= S_EXT2;
          end
        end
        S_EXT2: if (fetch_valid) begin
          pc_r    <= pc_r + `SBM_PC_STEP;
          state_r <= S_FETCH;
          if (ir_r[11:8] == `SBM_IMM_A24) begin
            // A nonzero top byte is flagged but the address is still kept.
            illegal_r <= (ext_val[31:24] != 8'h00);
            er_r[ir_r[2:0]] <= {8'h00, ext_val[23:0]};
          end else begin
            er_r[ir_r[2:0]] <= ext_val;
          end
        end
        S_RD: if (bus_done) begin
          case (kind_r)
            K_LDC: begin
              ccr_r   <= rd_data[15:8];
              state_r <= S_FETCH;
              if (ir_r[7]) begin
                er_r[ir_r[6:4]] <= ptr_reg + inc_amt(`SBM_SZ_WORD);
              end
            end
            K_MOV: begin
              wdata_r <= {8'h00, rd_data[7:0]};
              addr_r  <= er_r[6][23:0];
              we_r    <= 1'b1;
              state_r <= S_WR;
            end
            default: begin
              wdata_r <= {8'h00, bit_modify(rd_data[7:0], ir_r[11:8],
                                            bitn_r, ccr_r[`SBM_CCR_C])};
              we_r    <= 1'b1;
              state_r <= S_WR;
            end
          endcase
        end
        S_WR: if (bus_done) begin
          we_r    <= 1'b0;
          state_r <= S_FETCH;
          if (kind_r == K_STC && ir_r[7]) begin
            er_r[ir_r[6:4]] <= ptr_reg + inc_amt(`SBM_SZ_WORD);
          end
          if (kind_r == K_MOV) begin
            er_r[5] <= er_r[5] + inc_amt(`SBM_SZ_BYTE);
            er_r[6] <= er_r[6] + inc_amt(`SBM_SZ_BYTE);
            if (wcount_r) begin
              er_r[4][15:0] <= cnt_left;
            end else begin
              er_r[4][7:0] <= cnt_left[7:0];
            end
            if (cnt_left != 16'h0000) begin
              addr_r  <= er_r[5][23:0] + 24'h000001;
              state_r <= S_RD;
            end
          end
        end
        S_WAIT: if (exc_entry_valid) begin
          pc_r    <= exc_entry_pc;
          state_r <= S_FETCH;
        end
        S_SLEEP: if (wake) begin
          state_r <= S_FETCH;
        end
        default: state_r <= S_FETCH;
      endcase
    end
  end

endmodule // sbm_exec

`default_nettype wire

// >>> dv/sbm_exec_asserts.sv
// Checker for the execution unit, watching only the top-level ports.
// Assumes the core clock and the active-low reset of the bound unit.
`default_nettype none

module sbm_exec_chk (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        fetch_valid,
  input wire logic [15:0] fetch_word,
  input wire logic        fetch_ready,
  input wire logic [23:0] fetch_addr,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic        mem_word,
  input wire logic [23:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  input wire logic        mem_ack,
  input wire logic        wake,
  input wire logic        trap_start,
  input wire logic [1:0]  trap_vec,
  input wire logic        exc_return,
  input wire logic        power_down,
  input wire logic [7:0]  condition_code_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  wire       tk = fetch_valid && fetch_ready;
  wire [7:0] hb = fetch_word[15:8];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_nop_step: assert property (tk && fetch_word == 16'h0000 |=>
    fetch_addr == $past(fetch_addr) + 24'h000002 && !mem_req)
    else $error("no-operation did not just step the counter");
  chk_trap_pulse: assert property (tk && hb == 8'h01 |=>
    trap_start && trap_vec == $past(fetch_word[1:0]))
    else $error("trap not started with its vector");
  chk_trap_wait: assert property (trap_start |-> !fetch_ready)
    else $error("fetch continued after trap");
  chk_rte_pulse: assert property (tk && hb == 8'h02 |=> exc_return)
    else $error("exception return not signalled");
  chk_sleep_enter: assert property (tk && hb == 8'h03 |=>
    power_down && !fetch_ready)
    else $error("power-down not entered");
  chk_sleep_hold: assert property (power_down && !wake |=>
    power_down && !mem_req)
    else $error("activity while powered down");
  chk_and_flags: assert property (tk && hb == 8'h09 |=>
    condition_code_reg == ($past(condition_code_reg) & $past(fetch_word[7:0])))
    else $error("flag and wrong");
  chk_or_flags: assert property (tk && hb == 8'h0a |=>
    condition_code_reg == ($past(condition_code_reg) | $past(fetch_word[7:0])))
    else $error("flag or wrong");
  chk_xor_flags: assert property (tk && hb == 8'h0b |=>
    condition_code_reg == ($past(condition_code_reg) ^ $past(fetch_word[7:0])))
    else $error("flag xor wrong");
  chk_stc_word: assert property (mem_req && mem_we && mem_word |->
    mem_wdata[7:0] == 8'h00 && !mem_addr[0])
    else $error("flag store word malformed");
  chk_bus_hold: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("bus request changed before ack");

  cov_trap: cover property (trap_start);
  cov_rte: cover property (exc_return);
  cov_sleep: cover property (power_down);
  cov_write: cover property (mem_req && mem_we && mem_ack);
endmodule // sbm_exec_chk

bind sbm_exec sbm_exec_chk u_chk (.clk(clk), .nrst(nrst),
  .fetch_valid(fetch_valid), .fetch_word(fetch_word),
  .fetch_ready(fetch_ready), .fetch_addr(fetch_addr), .mem_req(mem_req),
  .mem_we(mem_we), .mem_word(mem_word), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_ack(mem_ack), .wake(wake),
  .trap_start(trap_start), .trap_vec(trap_vec), .exc_return(exc_return),
  .power_down(power_down), .condition_code_reg(condition_code_reg));
`default_nettype wire

// >>> dv/sbm_exec_bench.sv
// Self-checking bench for the execution unit with fetch and memory models.
// Assumes the unit answers on the core clock; stimulus moves on falling edges.
`default_nettype none

module system_ctrl_block_move_exec_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, nrst = 1'b0, fetch_valid = 1'b0, mem_ack = 1'b0;
  logic [15:0] fetch_word = 16'h0000, mem_rdata = 16'h0000;
  logic        exc_entry_valid = 1'b0, wake = 1'b0;
  logic [7:0]  irq_evt = 8'h00, ma, cm, v;
  wire         fetch_ready, mem_req, mem_we, mem_word, trap_start;
  wire         exc_return, power_down, illegal_instr;
  wire  [23:0] fetch_addr, mem_addr;
  wire  [15:0] mem_wdata;
  wire  [1:0]  trap_vec;
  wire  [7:0]  condition_code_reg, port_dir, irq_status;
  logic [15:0] prog [0:255];
  logic [7:0]  mem [0:255], em [0:255];
  logic [23:0] sa;
  int n_fail = 0, compares = 0, n_bus = 0, n_trap = 0, n_rte = 0, p, sp, i;
  int n_ill = 0;

  always #20 clk = ~clk;

  sbm_exec DUT (.clk(clk), .nrst(nrst), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .fetch_ready(fetch_ready),
    .fetch_addr(fetch_addr), .mem_req(mem_req), .mem_we(mem_we),
    .mem_word(mem_word), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .exc_entry_valid(exc_entry_valid), .exc_entry_pc(24'h000180),
    .wake(wake), .irq_evt(irq_evt), .trap_start(trap_start),
    .trap_vec(trap_vec), .exc_return(exc_return), .power_down(power_down),
    .illegal_instr(illegal_instr), .condition_code_reg(condition_code_reg), .port_dir(port_dir),
    .irq_status(irq_status));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic e(input logic [15:0] w);
    prog[p] = w;
    p++;
  endtask

  // Loads a whole 32-bit pointer as a high word then a low word.
  task automatic ld(input logic [2:0] r, input logic [31:0] val);
    e(16'h6100 | {13'h0000, r});
    e(val[31:16]);
    e(val[15:0]);
  endtask

  task automatic store_flags_instr;
    e(16'h0890);
    em[sp] = cm;
    em[sp + 1] = 8'h00;
    sp += 2;
  endtask

  // Fetch and memory stall at random; idle read data toggles every cycle.
  always @(negedge clk) begin
    fetch_valid <= ($urandom % 4) != 0;
    fetch_word <= prog[fetch_addr[8:1]];
    exc_entry_valid <= trap_start;
    if (trap_start) n_trap++;
    if (exc_return) n_rte++;
    if (illegal_instr) n_ill++;
    if (mem_req && !mem_ack && ($urandom % 2)) begin
      mem_ack <= 1'b1;
      n_bus++;
      ma = mem_addr[7:0];
      if (mem_we && mem_word) {mem[ma], mem[ma + 8'h01]} = mem_wdata;
      else if (mem_we) mem[ma] = mem_wdata[7:0];
      else mem_rdata <= mem_word ? {mem[ma], mem[ma + 8'h01]}
                                 : {8'h00, mem[ma]};
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end

  initial begin
    #(20000 * 40);
    n_fail++;
    stop_test();
  end

  initial begin
    void'($urandom(32'h783edab4));
    for (i = 0; i < 256; i++) begin
      prog[i] = 16'h0300;
      mem[i] = 8'($urandom);
      em[i] = mem[i];
    end
    p = 16'h0080;
    sp = 8'h80;
    ld(3'd1, 32'h00000080);
    v = 8'($urandom);
    e({8'h04, v});
    cm = v;
    store_flags_instr();
    v = 8'($urandom);
    e({8'h09, v});
    cm &= v;
    store_flags_instr();
    v = 8'($urandom);
    e({8'h0a, v});
    cm |= v;
    store_flags_instr();
    v = 8'($urandom);
    e({8'h0b, v});
    cm ^= v;
    store_flags_instr();
    ld(3'd2, 32'h00000030);
    e(16'h0620);
    cm = mem[8'h30];
    store_flags_instr();
    e(16'h0000);
    // Each bit operation uses its own code as the bit number.
    ld(3'd0, 32'h00000020);
    for (i = 0; i < 5; i++) begin
      e(16'h7000 | 16'(i * 16'h0110));
      case (i)
        0: em[8'h20][0] = 1'b1;
        1: em[8'h20][1] = 1'b0;
        2: em[8'h20][2] = ~em[8'h20][2];
        3: em[8'h20][3] = cm[0];
        default: em[8'h20][4] = ~cm[0];
      endcase
    end
    ld(3'd5, 32'h00000010);
    ld(3'd6, 32'h00000040);
    ld(3'd4, 32'h00000003);
    e(16'h0c00);
    for (i = 0; i < 3; i++) em[8'h40 + i] = em[8'h10 + i];
    e(16'h0d00);
    e(16'h6004);
    e(16'h0002);
    e(16'h0d00);
    for (i = 3; i < 5; i++) em[8'h40 + i] = em[8'h10 + i];
    e(16'h6203);
    e(16'h00ff);
    e(16'hfe00);
    e(16'h7053);
    e(16'h7103);
    e(16'h6207);
    e(16'h00ff);
    e(16'hfe01);
    e(16'h7127);
    // A never-branch falls through; an always-branch skips an illegal word.
    e(16'h4102);
    e(16'h4002);
    e(16'hffff);
    e(16'h0102);
    sa = 24'h000100 + 24'(2 * (p - 16'h0080));
    e(16'h0300);
    e(16'h0000);
    e(16'h0300);
    prog[8'hc0] = 16'h0200;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    irq_evt = 8'h24;
    @(negedge clk);
    irq_evt = 8'h00;
    for (i = 0; i < 6000 && power_down !== 1'b1; i++) @(negedge clk);
    check(fetch_addr, sa + 24'h000002);
    check(condition_code_reg, cm);
    check(n_trap, 1);
    check(trap_vec, 2'h2);
    check(n_rte, 1);
    check(port_dir, 8'hfe);
    check(irq_status, 8'h20);
    check(n_bus, 26);
    check(n_ill, 0);
    for (i = 0; i < 256; i++) check(mem[i], em[i]);
    wake = 1'b1;
    @(negedge clk);
    wake = 1'b0;
    for (i = 0; i < 40 && fetch_addr !== sa + 24'h000006; i++) @(negedge clk);
    @(negedge clk);
    check(power_down, 1'b1);
    check(fetch_addr, sa + 24'h000006);
    stop_test();
  end
endmodule // system_ctrl_block_move_exec_bench
`default_nettype wire
